// file: hdl/smc_base_timer.sv
`timescale 1ns/1ps
module smc_base_timer
  import smc_pkg::*;
#(
  parameter int unsigned CYCLES = BT_CYCLES
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  // carry pulse
  output logic      carry
);

  smc_bt_t s_r;
  smc_bt_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.carry = 1'b0;
    // frozen while the oscillator is stopped
    if (run) begin
      if (s_r.cnt == BT_W'(CYCLES - 1)) begin
        s_nxt.cnt   = '0;
        s_nxt.carry = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + BT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign carry = s_r.carry;

endmodule // smc_base_timer

// file: hdl/smc_edge_det.sv
`timescale 1ns/1ps
module smc_edge_det
  import smc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // level in, rise pulse out
  input  wire logic level,
  output logic      rise
);

  smc_edge_t s_r;
  smc_edge_t s_nxt;

  always_comb begin
    s_nxt.prev = level;
    s_nxt.rise = level & ~s_r.prev;
  end

  // prev starts high so a pin already high at reset gives no spurious reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_r <= '{prev: 1'b1, rise: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise = s_r.rise;

endmodule // smc_edge_det

// file: hdl/smc_pkg.sv
//Behaviour
// - power-on reset leaving clock-stop switches on power failure detection
// - clock-stop instruction honoured only with standby pin low, else nop
// - pin rising during clock-stop instruction: nop, execution continues
// - after pin rise, pin reset at next timer carry, stop or not
// - halt stops only instruction execution, peripherals keep running
// - clock-stop halts the oscillator, cpu and all peripherals stop
// - peripheral control register held in halt, reset by valid clock-stop
// - halt freezes program counter; valid clock-stop clears and freezes it
// - clock-stop turns display off and bidirectional outputs back to inputs
// - halt keeps display driven, leaves halt on enabled key input
// - frequency synthesizer disabled whenever standby pin is low
// - host raises standby pin to request reset; the rise is the trigger
// - base timer carry flag set once every 125 ms
package smc_pkg;

  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned BT_PERIOD_MS = 125;
  localparam int unsigned BT_CYCLES    = (CLK_HZ / 1000) * BT_PERIOD_MS;
  localparam int unsigned BT_W         = 24;

  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_PORT     = 8'h10;

  // peripheral control register fields
  localparam int unsigned CTRL_W       = 4;
  localparam int unsigned CTRL_SYNTH   = 0;
  localparam int unsigned CTRL_LCD     = 1;
  localparam int unsigned CTRL_DIR_LO  = 2;
  localparam logic [CTRL_W-1:0] CTRL_INIT = 4'h0;

  // port data register: bidir data [1:0], output-only data [5:2]
  localparam int unsigned PORT_W      = 6;
  localparam int unsigned PORT_OUT_LO = 2;
  localparam logic [PORT_W-1:0] PORT_INIT = 6'h00;

  // status register fields
  localparam int unsigned ST_STATE_LO = 0;
  localparam int unsigned ST_PIN      = 2;
  localparam int unsigned ST_PEND     = 3;
  localparam int unsigned ST_PFD      = 4;

  // interrupt status / mask bits
  localparam int unsigned IRQ_W       = 4;
  localparam int unsigned IRQ_CARRY   = 0;
  localparam int unsigned IRQ_PINRST  = 1;
  localparam int unsigned IRQ_STOPNOP = 2;
  localparam int unsigned IRQ_HALTREL = 3;
  localparam logic [IRQ_W-1:0] IRQ_INIT = 4'h0;

  typedef enum logic [1:0] {
    SMC_RUN  = 2'b00,
    SMC_HALT = 2'b01,
    SMC_STOP = 2'b11,
    SMC_WAKE = 2'b10
  } smc_state_t;

  typedef struct packed {
    smc_state_t        st;
    logic              pend;
    logic              hk;
    logic              ht;
    logic              pfd;
    logic              pc_clr;
    logic              rst_pulse;
    logic              init_pulse;
    logic [CTRL_W-1:0] ctrl;
    logic [PORT_W-1:0] port;
    logic [IRQ_W-1:0]  irq;
    logic [IRQ_W-1:0]  mask;
    logic [31:0]       rdata;
  } smc_regs_t;

  typedef struct packed {
    logic [BT_W-1:0] cnt;
    logic            carry;
  } smc_bt_t;

  typedef struct packed {
    logic prev;
    logic rise;
  } smc_edge_t;

endpackage

// file: hdl/smc_top.sv
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module smc_top
  import smc_pkg::*;
#(
  parameter int unsigned BT_CYCLES_P = BT_CYCLES
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // cpu instruction side
  input  wire logic        halt_exec,
  input  wire logic        halt_key_en,
  input  wire logic        halt_timer_en,
  input  wire logic        stop_exec,
  output logic             cpu_exec_en,
  output logic             pc_hold,
  output logic             pc_clear,
  output logic             periph_init,
  // power and standby pin
  input  wire logic        por_evt,
  input  wire logic        standby_pin,
  output logic             pin_reset,
  output logic             pfd_en,
  // clocking and timer
  output logic             osc_en,
  output logic             base_timer_carry_flag,
  // peripherals
  input  wire logic [2:0]  key_in,
  input  wire logic [1:0]  bidir_port_pins_i,
  output logic [1:0]       bidir_port_pins_o,
  output logic [1:0]       bidir_port_pins_oe,
  output logic [3:0]       out_port,
  output logic             synth_en,
  output logic             lcd_drive_en,
  // interrupt
  output logic             irq
);

  smc_regs_t r_r;
  smc_regs_t r_nxt;

  logic carry;
  logic pin_rise;
  logic timer_run;
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic stop_ok;
  logic stop_nop;
  logic halt_rel;
  logic [IRQ_W-1:0] ev;

  // next state, so no carry slips out on the edge that stops the oscillator
  assign timer_run = (r_nxt.st != SMC_STOP);

  smc_base_timer #(
    .CYCLES (BT_CYCLES_P)
  ) u_bt (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (timer_run),
    .carry    (carry)
  );

  smc_edge_det u_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .level    (standby_pin),
    .rise     (pin_rise)
  );

  // zero-wait slave; read data captured in the setup phase
  assign pready   = 1'b1;
  assign mapped   = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
                    (paddr == OFF_IRQ_STAT) || (paddr == OFF_IRQ_MASK) ||
                    (paddr == OFF_PORT);
  assign pslverr  = psel & penable & ~mapped;
  assign wr_acc   = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;

  // a stop that meets a high pin degrades to a nop
  assign stop_ok  = stop_exec & (r_r.st == SMC_RUN) & ~standby_pin;
  assign stop_nop = stop_exec & (r_r.st == SMC_RUN) & standby_pin;

  assign halt_rel = (r_r.st == SMC_HALT) &&
                    ((r_r.hk && (key_in != 3'b000)) ||
                     (r_r.ht && carry));

  always_comb begin
    ev = '0;
    ev[IRQ_CARRY]   = carry;
    ev[IRQ_PINRST]  = r_r.pend & carry;
    ev[IRQ_STOPNOP] = stop_nop;
    ev[IRQ_HALTREL] = halt_rel;
  end

  always_comb begin
    r_nxt = r_r;
    r_nxt.pc_clr     = 1'b0;
    r_nxt.rst_pulse  = 1'b0;
    r_nxt.init_pulse = 1'b0;

    // register writes at the access edge
    if (wr_acc) begin
      case (paddr)
        OFF_CTRL: begin
          r_nxt.ctrl = pwdata[CTRL_W-1:0];
        end
        OFF_STATUS: begin
          if (pwdata[ST_PFD]) begin
            r_nxt.pfd = 1'b0;
          end
        end
        OFF_IRQ_STAT: begin
          r_nxt.irq = r_r.irq & ~pwdata[IRQ_W-1:0];
        end
        OFF_IRQ_MASK: begin
          r_nxt.mask = pwdata[IRQ_W-1:0];
        end
        OFF_PORT: begin
          r_nxt.port = pwdata[PORT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // set wins over a same-cycle clear
    r_nxt.irq = r_nxt.irq | ev;

    // a rise is remembered until the next carry
    if (pin_rise) begin
      r_nxt.pend = 1'b1;
    end

    case (r_r.st)
      SMC_RUN: begin
        if (stop_ok) begin
          r_nxt.st         = SMC_STOP;
          r_nxt.ctrl       = CTRL_INIT;
          r_nxt.init_pulse = 1'b1;
          r_nxt.pc_clr     = 1'b1;
        end else if (halt_exec) begin
          r_nxt.st = SMC_HALT;
          r_nxt.hk = halt_key_en;
          r_nxt.ht = halt_timer_en;
        end
      end
      SMC_HALT: begin
        // peripherals and ctrl untouched here
        if (halt_rel) begin
          r_nxt.st = SMC_RUN;
        end
      end
      SMC_STOP: begin
        // oscillator restarts on pin rise, reset waits for the carry
        if (pin_rise) begin
          r_nxt.st = SMC_WAKE;
        end
      end
      SMC_WAKE: begin
      end
      default: begin
        r_nxt.st = SMC_RUN;
      end
    endcase

    // pin reset only on a carry, even with no stop before it
    if (r_r.pend && carry && r_r.st != SMC_STOP) begin
      r_nxt.st         = SMC_RUN;
      r_nxt.pend       = pin_rise;
      r_nxt.rst_pulse  = 1'b1;
      r_nxt.pc_clr     = 1'b1;
      r_nxt.init_pulse = 1'b1;
      r_nxt.ctrl       = CTRL_INIT;
      r_nxt.hk         = 1'b0;
      r_nxt.ht         = 1'b0;
    end

    // power-on reset out of clock-stop arms power failure detection
    if (por_evt) begin
      if (r_r.st == SMC_STOP) begin
        r_nxt.pfd = 1'b1;
      end
      r_nxt.st         = SMC_RUN;
      r_nxt.pend       = 1'b0;
      r_nxt.pc_clr     = 1'b1;
      r_nxt.init_pulse = 1'b1;
      r_nxt.ctrl       = CTRL_INIT;
      r_nxt.hk         = 1'b0;
      r_nxt.ht         = 1'b0;
    end

    // read data latched at setup so prdata is a flop in access
    if (rd_setup) begin
      r_nxt.rdata = 32'h0000_0000;
      case (paddr)
        OFF_CTRL: begin
          r_nxt.rdata[CTRL_W-1:0] = r_r.ctrl;
        end
        OFF_STATUS: begin
          r_nxt.rdata[ST_STATE_LO+1:ST_STATE_LO] = r_r.st;
          r_nxt.rdata[ST_PIN]  = standby_pin;
          r_nxt.rdata[ST_PEND] = r_r.pend;
          r_nxt.rdata[ST_PFD]  = r_r.pfd;
        end
        OFF_IRQ_STAT: begin
          r_nxt.rdata[IRQ_W-1:0] = r_r.irq;
        end
        OFF_IRQ_MASK: begin
          r_nxt.rdata[IRQ_W-1:0] = r_r.mask;
        end
        OFF_PORT: begin
          r_nxt.rdata[1:0] = bidir_port_pins_i;
          r_nxt.rdata[PORT_W-1:PORT_OUT_LO] =
            r_r.port[PORT_W-1:PORT_OUT_LO];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_r <= '{st: SMC_RUN, pend: 1'b0, hk: 1'b0, ht: 1'b0, pfd: 1'b0,
               pc_clr: 1'b0, rst_pulse: 1'b0, init_pulse: 1'b0,
               ctrl: CTRL_INIT, port: PORT_INIT, irq: IRQ_INIT,
               mask: IRQ_INIT, rdata: 32'h0000_0000};
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs
  assign prdata      = r_r.rdata;
  assign cpu_exec_en = (r_r.st == SMC_RUN);
  assign pc_hold     = (r_r.st != SMC_RUN);
  assign pc_clear    = r_r.pc_clr;
  assign periph_init = r_r.init_pulse;
  assign pin_reset   = r_r.rst_pulse;
  assign pfd_en      = r_r.pfd;
  assign osc_en      = (r_r.st != SMC_STOP);

  assign base_timer_carry_flag = carry;

  // synthesizer needs the pin high; software may still switch it off
  assign synth_en = r_r.ctrl[CTRL_SYNTH] & standby_pin & osc_en;

  // display stays on through halt, goes dark in clock-stop
  assign lcd_drive_en = r_r.ctrl[CTRL_LCD] & osc_en;

  // bidir pins fall back to inputs once the direction bits are initialised
  assign bidir_port_pins_o  = r_r.port[1:0];
  assign bidir_port_pins_oe = r_r.ctrl[CTRL_DIR_LO+1:CTRL_DIR_LO] &
                              {2{osc_en}};

  // output-only data is held across clock-stop
  assign out_port = r_r.port[PORT_W-1:PORT_OUT_LO];

  assign irq = |(r_r.irq & r_r.mask);

endmodule // smc_top

// file: tb/smc_host_model.sv
`timescale 1ns/1ps
module smc_host_model (
  // clock
  input wire logic       core_clk,
  // request from bench
  input wire logic       want_hi,
  input wire logic [3:0] lag,
  // standby pin
  output logic           standby_pin
);
  logic [3:0] cnt_r;
  initial standby_pin = 1'b0;
  initial cnt_r = 4'h0;
  // a slow host settles the pin only after lag cycles
  always @(posedge core_clk) begin
    if (want_hi == standby_pin) begin
      cnt_r <= 4'h0;
    end else if (cnt_r >= lag) begin
      standby_pin <= want_hi;
      cnt_r       <= 4'h0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule // smc_host_model

// file: tb/smc_props.sv
`timescale 1ns/1ps
module smc_props (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // cpu and pin side
  input wire logic       halt_exec,
  input wire logic       stop_exec,
  input wire logic       por_evt,
  input wire logic       standby_pin,
  // state outputs
  input wire logic       cpu_exec_en,
  input wire logic       pc_hold,
  input wire logic       pc_clear,
  input wire logic       periph_init,
  input wire logic       pin_reset,
  input wire logic       pfd_en,
  input wire logic       osc_en,
  input wire logic       base_timer_carry_flag,
  input wire logic [1:0] bidir_port_pins_oe,
  input wire logic       synth_en,
  input wire logic       lcd_drive_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_go_stop;
    cpu_exec_en && stop_exec && !standby_pin;
  endsequence
  sequence s_stopped;
    !osc_en && pc_clear && periph_init && pc_hold;
  endsequence
  sequence s_nop_stop;
    cpu_exec_en && stop_exec && standby_pin;
  endsequence

  chk_stop_taken: assert property (
    s_go_stop |=> s_stopped) else $error("clock stop not taken");
  chk_stop_nop: assert property (
    s_nop_stop |=> cpu_exec_en && osc_en && !pc_clear)
    else $error("clock stop not a nop");
  chk_halt_only: assert property (
    cpu_exec_en && halt_exec && !stop_exec |=>
    !cpu_exec_en && pc_hold && osc_en && !pc_clear)
    else $error("halt entry wrong");
  chk_stop_pins: assert property (
    !osc_en |-> !lcd_drive_en && bidir_port_pins_oe == 2'b00 && !synth_en)
    else $error("outputs live in clock stop");
  chk_synth_off: assert property (
    !standby_pin |-> !synth_en) else $error("synth on with pin low");
  chk_timer_frozen: assert property (
    !osc_en |-> !base_timer_carry_flag) else $error("carry in stop");
  chk_carry_gap: assert property (
    base_timer_carry_flag |=> !base_timer_carry_flag [*8])
    else $error("carry too soon");
  chk_pin_rst_sync: assert property (
    pin_reset |-> $past(base_timer_carry_flag) && pc_clear && periph_init)
    else $error("pin reset off carry");
  chk_por_pfd: assert property (
    por_evt && !osc_en |=> pfd_en && osc_en && pc_clear)
    else $error("por from stop wrong");
  // past guard: a rise may still be in the edge detector
  chk_stop_stays: assert property (
    !osc_en && !standby_pin && !$past(standby_pin) && !por_evt |=> !osc_en)
    else $error("left stop without cause");
endmodule // smc_props

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import smc_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        halt_exec, halt_key_en, halt_timer_en, stop_exec, por_evt;
  logic        cpu_exec_en, pc_hold, pc_clear, periph_init, pin_reset;
  logic        pfd_en, osc_en, carry, synth_en, lcd_drive_en, irq;
  logic        standby_pin, want_hi;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed, rv;
  logic [3:0]  out_port, lag;
  logic [2:0]  key_in;
  logic [1:0]  b_i, b_o, b_oe, b_ext;
  logic [31:0] exp_q[$];
  int          n_errors, cmp_count;

  assign b_i = (b_oe & b_o) | (~b_oe & b_ext);

  smc_top #(.BT_CYCLES_P(20)) u_smc_top (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .halt_exec, .halt_key_en, .halt_timer_en,
    .stop_exec, .cpu_exec_en, .pc_hold, .pc_clear, .periph_init,
    .por_evt, .standby_pin, .pin_reset, .pfd_en, .osc_en,
    .base_timer_carry_flag(carry), .key_in, .bidir_port_pins_i(b_i),
    .bidir_port_pins_o(b_o), .bidir_port_pins_oe(b_oe), .out_port,
    .synth_en, .lcd_drive_en, .irq);

  smc_host_model u_smc_host_model (.core_clk, .want_hi, .lag, .standby_pin);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // halt, stop and power-on events as one-cycle pulses
  task automatic cyc(input logic h, input logic s, input logic p);
    @(posedge core_clk);
    halt_exec <= h;
    stop_exec <= s;
    por_evt   <= p;
    @(posedge core_clk);
    halt_exec <= 1'b0;
    stop_exec <= 1'b0;
    por_evt   <= 1'b0;
    #1;
  endtask

  task automatic wt_rst;
    int n;
    n = 0;
    while (pin_reset !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("pin_reset", 32'h1, 32'(pin_reset));
    chk("pc_clear", 32'h1, 32'(pc_clear));
  endtask

  task automatic end_of_test;
    if (exp_q.size() != 0) n_errors++;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (psel && penable && pready) begin
      chk("pslverr", 32'(paddr > OFF_PORT), 32'(pslverr));
      if (!pwrite) begin
        chk("prdata", exp_q.pop_front(), prdata);
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_of_test;
  end

  initial begin
    {rst, halt_key_en} = 2'b11;
    {psel, penable, pwrite, halt_exec, halt_timer_en} = 5'h00;
    {stop_exec, por_evt, want_hi} = 3'b000;
    {paddr, pwdata, key_in, lag, b_ext} = 49'h0;
    seed = 32'd72710;
    n_errors = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h0);
    rd(OFF_IRQ_MASK, 32'h0);
    rd(8'h14, 32'h0);
    $display("test reset done");
    seed = xs(seed);
    rv = {28'h0, 3'b111, seed[0]};
    apb(1'b1, OFF_CTRL, rv);
    apb(1'b1, OFF_PORT, 32'h0000_003D);
    cyc(1'b1, 1'b0, 1'b0);
    chk("cpu_exec_en", 32'h0, 32'(cpu_exec_en));
    chk("pc_hold", 32'h1, 32'(pc_hold));
    chk("lcd", 32'h1, 32'(lcd_drive_en));
    chk("oe", 32'h3, 32'(b_oe));
    rd(OFF_CTRL, rv);
    rd(OFF_PORT, 32'h3D);
    seed = xs(seed);
    @(posedge core_clk);
    key_in <= seed[2:0] | 3'b001;
    repeat (2) @(posedge core_clk);
    #1;
    chk("cpu_exec_en", 32'h1, 32'(cpu_exec_en));
    @(posedge core_clk);
    key_in <= 3'b000;
    halt_key_en   <= 1'b0;
    halt_timer_en <= 1'b1;
    cyc(1'b1, 1'b0, 1'b0);
    chk("pc_hold", 32'h1, 32'(pc_hold));
    repeat (24) @(posedge core_clk);
    #1;
    chk("cpu_exec_en", 32'h1, 32'(cpu_exec_en));
    $display("test halt done");
    cyc(1'b0, 1'b1, 1'b0);
    chk("osc_en", 32'h0, 32'(osc_en));
    chk("pc_clear", 32'h1, 32'(pc_clear));
    chk("lcd", 32'h0, 32'(lcd_drive_en));
    chk("oe", 32'h0, 32'(b_oe));
    chk("out_port", 32'hF, 32'(out_port));
    rd(OFF_CTRL, 32'h0);
    rd(OFF_STATUS, 32'h3);
    rd(OFF_PORT, 32'h3C);
    apb(1'b1, OFF_IRQ_MASK, 32'h2);
    @(posedge core_clk);
    want_hi <= 1'b1;
    lag     <= 4'h5;
    wt_rst;
    rd(OFF_STATUS, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, OFF_IRQ_STAT, 32'h2);
    #1;
    chk("irq", 32'h0, 32'(irq));
    $display("test stop done");
    apb(1'b1, OFF_IRQ_MASK, 32'h4);
    cyc(1'b0, 1'b1, 1'b0);
    chk("cpu_exec_en", 32'h1, 32'(cpu_exec_en));
    chk("irq", 32'h1, 32'(irq));
    @(posedge core_clk);
    want_hi <= 1'b0;
    lag     <= 4'h0;
    repeat (3) @(posedge core_clk);
    want_hi <= 1'b1;
    wt_rst;
    $display("test nop done");
    @(posedge core_clk);
    want_hi <= 1'b0;
    repeat (3) @(posedge core_clk);
    apb(1'b1, OFF_CTRL, 32'h1);
    #1;
    chk("synth_en", 32'h0, 32'(synth_en));
    cyc(1'b0, 1'b1, 1'b0);
    cyc(1'b0, 1'b0, 1'b1);
    chk("pfd_en", 32'h1, 32'(pfd_en));
    rd(OFF_STATUS, 32'h10);
    apb(1'b1, OFF_CTRL, 32'h1);
    @(posedge core_clk);
    want_hi <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("synth_en", 32'h1, 32'(synth_en));
    wt_rst;
    $display("test por done");
    end_of_test;
  end
endmodule // tb

bind smc_top smc_props u_smc_props (
  .core_clk, .rst, .halt_exec, .stop_exec, .por_evt, .standby_pin,
  .cpu_exec_en, .pc_hold, .pc_clear, .periph_init, .pin_reset, .pfd_en,
  .osc_en, .base_timer_carry_flag, .bidir_port_pins_oe, .synth_en,
  .lcd_drive_en);
